// File: verilog/receiver_cfg_pkg.sv
// Constants for the receiver configuration and status register bank.
// Assumes an 8-bit register port with 10-bit byte addresses on sys_clk.
// Functional notes
// - Timestamp delay has no effect while sync mode is normal.
// - Sync mode code 00 means normal, code 01 means timestamp.
// - N-shot skips the first N reference edges; zero uses the next one.
// - Status reports divider phase at capture, in half input clock steps.
// - Q-ignore bit clear gives I and Q; set gives I only.
// - Decimation codes 0 to 3 select divide by 1, 2, 4 or 8.
// - Force bit clear lets flag pins work normally; set forces them.
// - While forcing, flag pins show the force-value bit.
// - Reference mode picks disabled, continuous or N-shot capture.
`default_nettype none
package receiver_cfg_pkg;
  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 8;
  localparam int IGN_W   = 4;
  localparam int PHASE_W = 4;
  localparam int THR_HI_W = 5;

  localparam logic [ADDR_W-1:0] OFS_IGNORE     = 10'h121;
  localparam logic [ADDR_W-1:0] OFS_TS_DELAY   = 10'h123;
  localparam logic [ADDR_W-1:0] OFS_SETUP_HOLD = 10'h128;
  localparam logic [ADDR_W-1:0] OFS_DIV_PHASE  = 10'h129;
  localparam logic [ADDR_W-1:0] OFS_EVT_COUNT  = 10'h12a;
  localparam logic [ADDR_W-1:0] OFS_SYNC_MODE  = 10'h1ff;
  localparam logic [ADDR_W-1:0] OFS_APP_MODE   = 10'h200;
  localparam logic [ADDR_W-1:0] OFS_DECIM      = 10'h201;
  localparam logic [ADDR_W-1:0] OFS_OFFSET     = 10'h228;
  localparam logic [ADDR_W-1:0] OFS_FD_CTRL    = 10'h245;
  localparam logic [ADDR_W-1:0] OFS_UTH_LO     = 10'h247;
  localparam logic [ADDR_W-1:0] OFS_UTH_HI     = 10'h248;
  localparam logic [ADDR_W-1:0] OFS_LTH_LO     = 10'h249;
  localparam logic [ADDR_W-1:0] OFS_LTH_HI     = 10'h24a;

  localparam logic [DATA_W-1:0] RST_IGNORE   = 8'h00;
  localparam logic [DATA_W-1:0] RST_TS_DELAY = 8'h00;
  localparam logic [DATA_W-1:0] RST_SYNC     = 8'h00;
  localparam logic [DATA_W-1:0] RST_APP      = 8'h07;
  localparam logic [DATA_W-1:0] RST_DECIM    = 8'h01;
  localparam logic [DATA_W-1:0] RST_OFFSET   = 8'h00;
  localparam logic [DATA_W-1:0] RST_FD_CTRL  = 8'h00;
  localparam logic [DATA_W-1:0] RST_THRESH   = 8'h00;

  localparam int APP_QIGN_BIT  = 5;
  localparam int FD_FORCE_BIT  = 3;
  localparam int FD_FVAL_BIT   = 2;
  localparam int FD_EN_BIT     = 0;
  localparam int DEC_W         = 3;
  localparam int SYNC_W        = 2;

  localparam logic [SYNC_W-1:0] SYNC_NORMAL    = 2'h0;
  localparam logic [SYNC_W-1:0] SYNC_TIMESTAMP = 2'h1;

  typedef enum logic [1:0] {
    REF_DISABLED   = 2'b00,
    REF_CONTINUOUS = 2'b01,
    REF_NSHOT      = 2'b10
  } ref_mode_e;

  typedef enum logic [0:0] {
    CAP_HUNT  = 1'b0,
    CAP_SPENT = 1'b1
  } cap_state_e;
endpackage
`default_nettype wire

// File: verilog/ref_cap_if.sv
// Carrier between the register bank and the reference capture unit.
// Assumes both ends run on sys_clk.
`default_nettype none
interface ref_cap_if;
  import receiver_cfg_pkg::*;
  logic               ref_level;
  logic               falling_sel;
  logic [1:0]         mode;
  logic [IGN_W-1:0]   ignore_count;
  logic               rearm;
  logic [PHASE_W-1:0] div_phase;
  logic               captured;
  logic [PHASE_W-1:0] phase;
  logic [DATA_W-1:0]  event_count;
  modport owner (output ref_level, falling_sel, mode, ignore_count, rearm, div_phase,
                 input captured, phase, event_count);
  modport capture (input ref_level, falling_sel, mode, ignore_count, rearm, div_phase,
                   output captured, phase, event_count);
endinterface
`default_nettype wire

// File: verilog/ref_capture.sv
// Reference edge capture: edge select, N-shot ignore counting, phase and count.
// Assumes ref_level is already synchronised to sys_clk.
`default_nettype none
module ref_capture
  import receiver_cfg_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  ref_cap_if.capture cap
);
  logic               prev_reg,  prev_next;
  cap_state_e         state_reg, state_next;
  logic [IGN_W-1:0]   skip_reg,  skip_next;
  logic               cap_reg,   cap_next;
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic [DATA_W-1:0]  cnt_reg,   cnt_next;
  logic               edge_seen;
  logic               take;

  always_comb begin
    edge_seen  = cap.falling_sel ? (prev_reg & ~cap.ref_level)
                                 : (~prev_reg & cap.ref_level);
    prev_next  = cap.ref_level;
    state_next = state_reg;
    skip_next  = skip_reg;
    take       = 1'b0;
    unique case (cap.mode)
      REF_CONTINUOUS: begin
        take       = edge_seen;
        state_next = CAP_HUNT;
        skip_next  = '0;
      end
      REF_NSHOT: begin
        if (cap.rearm) begin
          state_next = CAP_HUNT;
          skip_next  = '0;
        end else if (state_reg == CAP_HUNT && edge_seen) begin
          // Edges before the programmed count are only counted
          if (skip_reg >= cap.ignore_count) begin
            take       = 1'b1;
            state_next = CAP_SPENT;
          end else begin
            skip_next = IGN_W'(skip_reg + 1'b1);
          end
        end
      end
      default: begin // Disabled, and the unused code, capture nothing
        state_next = CAP_HUNT;
        skip_next  = '0;
      end
    endcase
    cap_next   = take;
    phase_next = take ? cap.div_phase : phase_reg;
    cnt_next   = take ? DATA_W'(cnt_reg + 1'b1) : cnt_reg;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg  <= 1'b0;
      state_reg <= CAP_HUNT;
      skip_reg  <= '0;
      cap_reg   <= 1'b0;
      phase_reg <= '0;
      cnt_reg   <= '0;
    end else begin
      prev_reg  <= prev_next;
      state_reg <= state_next;
      skip_reg  <= skip_next;
      cap_reg   <= cap_next;
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign cap.captured    = cap_reg;
  assign cap.phase       = phase_reg;
  assign cap.event_count = cnt_reg;
endmodule
`default_nettype wire

// File: verilog/receiver_chip_config_regs.sv
// Configuration and status register bank of a dual-channel receiver.
// Assumes a one-cycle strobe register port on sys_clk; ref_pin is asynchronous,
// all other inputs come from logic on sys_clk.
`default_nettype none
module receiver_chip_config_regs
  import receiver_cfg_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [DATA_W-1:0]   reg_rdata,
  input  wire logic                ref_pin,
  input  wire logic [1:0]          ref_mode,
  input  wire logic                ref_falling_sel,
  input  wire logic [PHASE_W-1:0]  clk_div_phase,
  input  wire logic [DATA_W-1:0]   setup_hold_in,
  input  wire logic                overrange_raw_a,
  input  wire logic                overrange_raw_b,
  output var  logic                overrange_flag_pin_a,
  output var  logic                overrange_flag_pin_b,
  output wire logic                ref_capture_pulse,
  output var  logic                timestamp_mode,
  output var  logic [DATA_W-1:0]   timestamp_delay_eff,
  output var  logic                q_output_en,
  output var  logic [3:0]          channel_config,
  output var  logic [3:0]          decimation_factor,
  output var  logic [DATA_W-1:0]   sample_offset,
  output var  logic                overrange_detect_en,
  output var  logic [12:0]         upper_thresh,
  output var  logic [12:0]         lower_thresh
);
  if (SYNC_STAGES < 2) begin : g_check
    $error("SYNC_STAGES must be at least 2");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [3:0] dec_factor(input logic [DEC_W-1:0] code);
    unique case (code)
      3'h0:    dec_factor = 4'h1;
      3'h1:    dec_factor = 4'h2;
      3'h2:    dec_factor = 4'h4;
      3'h3:    dec_factor = 4'h8;
      default: dec_factor = 4'h1;
    endcase
  endfunction

  // Only code 01 selects timestamp; the spare codes fall back to normal
  function automatic logic is_timestamp(input logic [SYNC_W-1:0] code);
    is_timestamp = (code == SYNC_TIMESTAMP);
  endfunction

  // Output flops start from what the reset register values decode to
  localparam logic [3:0] DFAC_RST = dec_factor(RST_DECIM[DEC_W-1:0]);
  localparam logic       QEN_RST  = ~RST_APP[APP_QIGN_BIT];

  // Reference pin synchroniser
  // Only the last stage is read, so a metastable first stage never reaches logic
  logic [SYNC_STAGES-1:0] sync_reg, sync_next;

  always_comb begin
    sync_next = {sync_reg[SYNC_STAGES-2:0], ref_pin};
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Software registers
  logic [IGN_W-1:0]    ign_reg,    ign_next;
  logic [DATA_W-1:0]   tsd_reg,    tsd_next;
  logic [SYNC_W-1:0]   smode_reg,  smode_next;
  logic                qign_reg,   qign_next;
  logic [3:0]          opmode_reg, opmode_next;
  logic [DEC_W-1:0]    dec_reg,    dec_next;
  logic [DATA_W-1:0]   offs_reg,   offs_next;
  logic                force_reg,  force_next;
  logic                fval_reg,   fval_next;
  logic                fden_reg,   fden_next;
  logic [DATA_W-1:0]   uthl_reg,   uthl_next;
  logic [THR_HI_W-1:0] uthh_reg,   uthh_next;
  logic [DATA_W-1:0]   lthl_reg,   lthl_next;
  logic [THR_HI_W-1:0] lthh_reg,   lthh_next;
  logic [DATA_W-1:0]   shs_reg,    shs_next;
  logic                rearm;

  // Writes to status and counter offsets fall through untouched
  always_comb begin
    ign_next    = ign_reg;
    tsd_next    = tsd_reg;
    smode_next  = smode_reg;
    qign_next   = qign_reg;
    opmode_next = opmode_reg;
    dec_next    = dec_reg;
    offs_next   = offs_reg;
    force_next  = force_reg;
    fval_next   = fval_reg;
    fden_next   = fden_reg;
    uthl_next   = uthl_reg;
    uthh_next   = uthh_reg;
    lthl_next   = lthl_reg;
    lthh_next   = lthh_reg;
    shs_next    = setup_hold_in;
    rearm       = 1'b0;
    if (reg_wr) begin
      if (hit(reg_addr, OFS_IGNORE)) begin
        ign_next = reg_wdata[IGN_W-1:0];
        // A new count restarts the N-shot search
        rearm    = 1'b1;
      end
      if (hit(reg_addr, OFS_TS_DELAY)) begin
        tsd_next = reg_wdata;
      end
      if (hit(reg_addr, OFS_SYNC_MODE)) begin
        smode_next = reg_wdata[SYNC_W-1:0];
      end
      if (hit(reg_addr, OFS_APP_MODE)) begin
        qign_next   = reg_wdata[APP_QIGN_BIT];
        opmode_next = reg_wdata[3:0];
      end
      if (hit(reg_addr, OFS_DECIM)) begin
        dec_next = reg_wdata[DEC_W-1:0];
      end
      if (hit(reg_addr, OFS_OFFSET)) begin
        offs_next = reg_wdata;
      end
      if (hit(reg_addr, OFS_FD_CTRL)) begin
        force_next = reg_wdata[FD_FORCE_BIT];
        fval_next  = reg_wdata[FD_FVAL_BIT];
        fden_next  = reg_wdata[FD_EN_BIT];
      end
      if (hit(reg_addr, OFS_UTH_LO)) begin
        uthl_next = reg_wdata;
      end
      if (hit(reg_addr, OFS_UTH_HI)) begin
        uthh_next = reg_wdata[THR_HI_W-1:0];
      end
      if (hit(reg_addr, OFS_LTH_LO)) begin
        lthl_next = reg_wdata;
      end
      if (hit(reg_addr, OFS_LTH_HI)) begin
        lthh_next = reg_wdata[THR_HI_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ign_reg    <= RST_IGNORE[IGN_W-1:0];
      tsd_reg    <= RST_TS_DELAY;
      smode_reg  <= RST_SYNC[SYNC_W-1:0];
      qign_reg   <= RST_APP[APP_QIGN_BIT];
      opmode_reg <= RST_APP[3:0];
      dec_reg    <= RST_DECIM[DEC_W-1:0];
      offs_reg   <= RST_OFFSET;
      force_reg  <= RST_FD_CTRL[FD_FORCE_BIT];
      fval_reg   <= RST_FD_CTRL[FD_FVAL_BIT];
      fden_reg   <= RST_FD_CTRL[FD_EN_BIT];
      uthl_reg   <= RST_THRESH;
      uthh_reg   <= RST_THRESH[THR_HI_W-1:0];
      lthl_reg   <= RST_THRESH;
      lthh_reg   <= RST_THRESH[THR_HI_W-1:0];
      shs_reg    <= '0;
    end else begin
      ign_reg    <= ign_next;
      tsd_reg    <= tsd_next;
      smode_reg  <= smode_next;
      qign_reg   <= qign_next;
      opmode_reg <= opmode_next;
      dec_reg    <= dec_next;
      offs_reg   <= offs_next;
      force_reg  <= force_next;
      fval_reg   <= fval_next;
      fden_reg   <= fden_next;
      uthl_reg   <= uthl_next;
      uthh_reg   <= uthh_next;
      lthl_reg   <= lthl_next;
      lthh_reg   <= lthh_next;
      shs_reg    <= shs_next;
    end
  end

  // Reference capture unit
  ref_cap_if cap_bus ();

  assign cap_bus.ref_level    = sync_reg[SYNC_STAGES-1];
  assign cap_bus.falling_sel  = ref_falling_sel;
  assign cap_bus.mode         = ref_mode;
  assign cap_bus.ignore_count = ign_reg;
  assign cap_bus.rearm        = rearm;
  assign cap_bus.div_phase    = clk_div_phase;

  ref_capture u_capture (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .cap     (cap_bus)
  );

  assign ref_capture_pulse = cap_bus.captured;

  // Read port: data only in the cycle after the strobe, zero elsewhere
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_IGNORE:     rdata_next = {4'h0, ign_reg};
        OFS_TS_DELAY:   rdata_next = tsd_reg;
        OFS_SETUP_HOLD: rdata_next = shs_reg;
        OFS_DIV_PHASE:  rdata_next = {4'h0, cap_bus.phase};
        OFS_EVT_COUNT:  rdata_next = cap_bus.event_count;
        OFS_SYNC_MODE:  rdata_next = {6'h00, smode_reg};
        OFS_APP_MODE:   rdata_next = {2'h0, qign_reg, 1'b0, opmode_reg};
        OFS_DECIM:      rdata_next = {5'h00, dec_reg};
        OFS_OFFSET:     rdata_next = offs_reg;
        OFS_FD_CTRL:    rdata_next = {4'h0, force_reg, fval_reg, 1'b0, fden_reg};
        OFS_UTH_LO:     rdata_next = uthl_reg;
        OFS_UTH_HI:     rdata_next = {3'h0, uthh_reg};
        OFS_LTH_LO:     rdata_next = lthl_reg;
        OFS_LTH_HI:     rdata_next = {3'h0, lthh_reg};
        default:        rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // Registered datapath controls; they lag the register write by one cycle
  logic              fda_reg,  fda_next;
  logic              fdb_reg,  fdb_next;
  logic              tsm_reg,  tsm_next;
  logic [DATA_W-1:0] tsde_reg, tsde_next;
  logic              qen_reg,  qen_next;
  logic [3:0]        dfac_reg, dfac_next;

  always_comb begin
    if (force_reg) begin
      fda_next = fval_reg;
      fdb_next = fval_reg;
    end else begin
      fda_next = fden_reg & overrange_raw_a;
      fdb_next = fden_reg & overrange_raw_b;
    end
    tsm_next  = is_timestamp(smode_reg);
    // Delay is masked so a stale value cannot shift normal-mode sync
    tsde_next = is_timestamp(smode_reg) ? tsd_reg : '0;
    qen_next  = ~qign_reg;
    dfac_next = dec_factor(dec_reg);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fda_reg  <= 1'b0;
      fdb_reg  <= 1'b0;
      tsm_reg  <= 1'b0;
      tsde_reg <= '0;
      qen_reg  <= QEN_RST;
      dfac_reg <= DFAC_RST;
    end else begin
      fda_reg  <= fda_next;
      fdb_reg  <= fdb_next;
      tsm_reg  <= tsm_next;
      tsde_reg <= tsde_next;
      qen_reg  <= qen_next;
      dfac_reg <= dfac_next;
    end
  end

  assign overrange_flag_pin_a = fda_reg;
  assign overrange_flag_pin_b = fdb_reg;
  assign timestamp_mode       = tsm_reg;
  assign timestamp_delay_eff  = tsde_reg;
  assign q_output_en          = qen_reg;
  assign decimation_factor    = dfac_reg;
  assign channel_config       = opmode_reg;
  assign sample_offset        = offs_reg;
  assign overrange_detect_en  = fden_reg;
  assign upper_thresh         = {uthh_reg, uthl_reg};
  assign lower_thresh         = {lthh_reg, lthl_reg};
endmodule
`default_nettype wire

// File: verif/receiver_cfg_chk.sv
// Checker for the receiver register bank, watching top-level ports only.
// Assumes it is bound onto receiver_chip_config_regs and shares its clock.
`default_nettype none
module receiver_cfg_chk
  import receiver_cfg_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              ref_pin,
  input wire logic [1:0]        ref_mode,
  input wire logic              ref_falling_sel,
  input wire logic              overrange_raw_a,
  input wire logic              overrange_raw_b,
  input wire logic              overrange_flag_pin_a,
  input wire logic              overrange_flag_pin_b,
  input wire logic              ref_capture_pulse,
  input wire logic              timestamp_mode,
  input wire logic [DATA_W-1:0] timestamp_delay_eff,
  input wire logic              q_output_en,
  input wire logic [3:0]        decimation_factor
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LAT = SYNC_STAGES + 1;
  logic [3:0] fd_reg;
  logic [1:0] sync_reg;
  logic [7:0] dly_reg;
  logic       qign_reg;
  logic [2:0] dec_reg;
  logic       exp_a;
  logic       exp_b;
  logic [7:0] exp_dly;
  logic [3:0] exp_dec;
  // Shadows of what software wrote, so outputs are judged against the write side
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fd_reg <= 4'h0;
      sync_reg <= 2'h0;
      dly_reg <= 8'h00;
      qign_reg <= 1'b0;
      dec_reg <= 3'h1;
    end else if (reg_wr) begin
      if (reg_addr == OFS_FD_CTRL) fd_reg <= reg_wdata[3:0];
      if (reg_addr == OFS_SYNC_MODE) sync_reg <= reg_wdata[1:0];
      if (reg_addr == OFS_TS_DELAY) dly_reg <= reg_wdata;
      if (reg_addr == OFS_APP_MODE) qign_reg <= reg_wdata[APP_QIGN_BIT];
      if (reg_addr == OFS_DECIM) dec_reg <= reg_wdata[2:0];
    end
  end
  assign exp_a = fd_reg[3] ? fd_reg[2] : (fd_reg[0] & overrange_raw_a);
  assign exp_b = fd_reg[3] ? fd_reg[2] : (fd_reg[0] & overrange_raw_b);
  assign exp_dly = (sync_reg == SYNC_TIMESTAMP) ? dly_reg : 8'h00;
  assign exp_dec = (dec_reg < 3'h4) ? (4'h1 << dec_reg) : 4'h1;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  fd_pin_a_a: assert property (overrange_flag_pin_a == $past(exp_a))
    else $error("flag pin a differs from control setting");
  fd_pin_b_a: assert property (overrange_flag_pin_b == $past(exp_b))
    else $error("flag pin b differs from control setting");
  ts_mode_a: assert property (timestamp_mode == ($past(sync_reg) == SYNC_TIMESTAMP))
    else $error("timestamp mode output wrong");
  ts_delay_a: assert property (timestamp_delay_eff == $past(exp_dly))
    else $error("effective delay wrong");
  q_out_a: assert property (q_output_en == !$past(qign_reg))
    else $error("q output enable wrong");
  decim_a: assert property (decimation_factor == $past(exp_dec))
    else $error("decimation factor wrong");
  rd_sync_a: assert property ($past(reg_rd && reg_addr == OFS_SYNC_MODE)
    |-> reg_rdata == {6'h00, $past(sync_reg)}) else $error("sync mode readback wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  pulse_width_a: assert property (ref_capture_pulse |=> !ref_capture_pulse)
    else $error("capture pulse too long");
  ref_off_a: assert property ((ref_mode == 2'b00)[*5] |-> !ref_capture_pulse)
    else $error("capture while disabled");
  ref_edge_a: assert property (ref_capture_pulse |->
    $past(ref_pin, LAT) != $past(ref_falling_sel) &&
    $past(ref_pin, LAT) != $past(ref_pin, LAT + 1))
    else $error("capture without matching edge");

  cover property (ref_capture_pulse);
  cover property (timestamp_mode && timestamp_delay_eff != 8'h00);
  cover property (overrange_flag_pin_a && overrange_flag_pin_b && !overrange_raw_a);
endmodule
bind receiver_chip_config_regs receiver_cfg_chk #(.SYNC_STAGES(SYNC_STAGES)) u_chk (
  .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_pin,
  .ref_mode, .ref_falling_sel, .overrange_raw_a, .overrange_raw_b, .overrange_flag_pin_a,
  .overrange_flag_pin_b, .ref_capture_pulse, .timestamp_mode, .timestamp_delay_eff,
  .q_output_en, .decimation_factor);
`default_nettype wire

// File: verif/tb_receiver_chip_config_regs.sv
// Self-checking bench for the receiver register bank over its strobe port.
// Assumes the checker is bound separately; one clock, no partner model.
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb_receiver_chip_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import receiver_cfg_pkg::*;
  logic              sys_clk;
  logic              nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              ref_pin = 1'b0;
  logic [1:0]        ref_mode = 2'b00;
  logic              ref_falling_sel = 1'b0;
  logic [3:0]        clk_div_phase = 4'h0;
  logic [7:0]        setup_hold_in = 8'h5a;
  logic              overrange_raw_a = 1'b0;
  logic              overrange_raw_b = 1'b0;
  logic              overrange_flag_pin_a, overrange_flag_pin_b, ref_capture_pulse;
  logic              timestamp_mode, q_output_en, overrange_detect_en;
  logic [7:0]        timestamp_delay_eff, sample_offset;
  logic [3:0]        channel_config, decimation_factor;
  logic [12:0]       upper_thresh, lower_thresh;
  int                bad_count = 0;
  int                check_count = 0;
  localparam logic [9:0] ADR [11] = '{OFS_IGNORE, OFS_TS_DELAY, OFS_SYNC_MODE, OFS_APP_MODE,
    OFS_DECIM, OFS_OFFSET, OFS_FD_CTRL, OFS_UTH_LO, OFS_UTH_HI, OFS_LTH_LO, OFS_LTH_HI};
  localparam logic [7:0] RSTV [11] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h01, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  // Reserved bits must read back as zero after an all-ones write
  localparam logic [7:0] MASK [11] = '{8'h0f, 8'hff, 8'h03, 8'h2f, 8'h07, 8'hff, 8'h0d,
    8'hff, 8'h1f, 8'hff, 8'h1f};
  localparam logic [7:0] FDC [4] = '{8'h01, 8'h08, 8'h0c, 8'h00};
  localparam logic [1:0] RAW [4] = '{2'b10, 2'b11, 2'b00, 2'b11};
  localparam logic [1:0] FEXP [4] = '{2'b10, 2'b00, 2'b11, 2'b00};

  receiver_chip_config_regs #(.SYNC_STAGES(2)) DUT (
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_pin,
    .ref_mode, .ref_falling_sel, .clk_div_phase, .setup_hold_in, .overrange_raw_a,
    .overrange_raw_b, .overrange_flag_pin_a, .overrange_flag_pin_b, .ref_capture_pulse,
    .timestamp_mode, .timestamp_delay_eff, .q_output_en, .channel_config,
    .decimation_factor, .sample_offset, .overrange_detect_en, .upper_thresh, .lower_thresh);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("read %h", a), e, reg_rdata)
  endtask

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  // Toggles the reference k times high and low, counting capture pulses
  task automatic edges(input int k, input int e);
    int n;
    n = 0;
    repeat (2 * k) begin
      @(posedge sys_clk);
      ref_pin <= !ref_pin;
      repeat (8) begin
        @(posedge sys_clk);
        #1;
        if (ref_capture_pulse === 1'b1) n++;
      end
    end
    `CHK("capture pulses", e, n)
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 11; i++) rc(ADR[i], RSTV[i]);
    rc(OFS_SETUP_HOLD, 8'h5a);
    rc(OFS_EVT_COUNT, 8'h00);
    `CHK("decimation_factor", 4'h2, decimation_factor)
    `CHK("q_output_en", 1'b1, q_output_en)
    for (int i = 0; i < 11; i++) begin
      wr(ADR[i], 8'hff);
      rc(ADR[i], MASK[i]);
    end
    wr(OFS_DIV_PHASE, 8'hff);
    wr(OFS_EVT_COUNT, 8'hff);
    wr(10'h300, 8'hff);
    rc(OFS_DIV_PHASE, 8'h00);
    rc(OFS_EVT_COUNT, 8'h00);
    rc(10'h300, 8'h00);
    @(posedge sys_clk);
    setup_hold_in <= 8'ha5;
    rc(OFS_SETUP_HOLD, 8'ha5);
    `CHK("timestamp_mode", 1'b0, timestamp_mode)
    `CHK("q_output_en", 1'b0, q_output_en)
    `CHK("upper_thresh", 13'h1fff, upper_thresh)
    `CHK("lower_thresh", 13'h1fff, lower_thresh)
    `CHK("detect_en", 1'b1, overrange_detect_en)
    `CHK("sample_offset", 8'hff, sample_offset)
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SYNC_MODE, 8'(c));
      step();
      `CHK("timestamp_mode", c == 1, timestamp_mode)
      `CHK("delay_eff", (c == 1) ? 8'hff : 8'h00, timestamp_delay_eff)
    end
    for (int c = 0; c < 8; c++) begin
      wr(OFS_DECIM, 8'(c));
      step();
      `CHK("decimation_factor", (c < 4) ? 4'(1 << c) : 4'h1, decimation_factor)
    end
    wr(OFS_APP_MODE, 8'h03);
    step();
    `CHK("q_output_en", 1'b1, q_output_en)
    `CHK("channel_config", 4'h3, channel_config)
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {overrange_raw_a, overrange_raw_b} <= RAW[i];
      wr(OFS_FD_CTRL, FDC[i]);
      step();
      `CHK("flag pins", FEXP[i], {overrange_flag_pin_a, overrange_flag_pin_b})
    end
    @(posedge sys_clk);
    ref_mode <= 2'b01;
    clk_div_phase <= 4'h9;
    edges(2, 2);
    @(posedge sys_clk);
    clk_div_phase <= 4'h5;
    rc(OFS_DIV_PHASE, 8'h09);
    rc(OFS_EVT_COUNT, 8'h02);
    @(posedge sys_clk);
    ref_mode <= 2'b00;
    edges(1, 0);
    wr(OFS_IGNORE, 8'h01);
    @(posedge sys_clk);
    ref_mode <= 2'b10;
    clk_div_phase <= 4'h3;
    edges(3, 1);
    wr(OFS_IGNORE, 8'h00);
    edges(2, 1);
    @(posedge sys_clk);
    clk_div_phase <= 4'h6;
    rc(OFS_DIV_PHASE, 8'h03);
    rc(OFS_EVT_COUNT, 8'h04);
    conclude();
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    $display("Watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire
